// [design/sol_pkg.sv]
/*
  shared constants, the link event carrier and opcode decoders for the
  secured one-time area lock control.
  assumes: single-byte opcodes, 3-byte addresses, byte-wide link data.
*/
`default_nettype none
package sol_pkg;
  // opcodes seen by this block
  localparam logic [7:0] OP_ENTER = 8'hb1; // enter one-time area mode
  localparam logic [7:0] OP_EXIT = 8'hc1; // leave one-time area mode
  localparam logic [7:0] OP_RDSEC = 8'h2b; // read lock status
  localparam logic [7:0] OP_WRSEC = 8'h2f; // write lock status
  localparam logic [7:0] OP_WRSR1 = 8'h01; // status register 1 write
  localparam logic [7:0] OP_WRSR2 = 8'h31; // status register 2 write
  localparam logic [7:0] OP_PP = 8'h02; // page program
  localparam logic [7:0] OP_QPP = 8'h32; // quad page program
  localparam logic [7:0] OP_RD = 8'h03; // read
  localparam logic [7:0] OP_FRD = 8'h0b; // fast read
  localparam logic [7:0] OP_QRD = 8'heb; // quad io read
  localparam logic [7:0] OP_SE = 8'h20; // 4 kB erase
  localparam logic [7:0] OP_BE32 = 8'h52; // 32 kB erase
  localparam logic [7:0] OP_BE64 = 8'hd8; // 64 kB erase
  localparam logic [7:0] OP_CE1 = 8'hc7; // chip erase
  localparam logic [7:0] OP_CE2 = 8'h60; // chip erase, alias
  // lock status field positions
  localparam int SEC_FACT_BIT = 0;
  localparam int SEC_CUST_BIT = 1;
  // one-time area map
  localparam logic [23:0] SERIAL_LAST = 24'h00000f;
  localparam logic [23:0] OTP_LAST = 24'h0001ff;
  // byte counts within a frame
  localparam logic [2:0] ADDR_END = 3'h4; // opcode plus 3 address bytes
  localparam logic [2:0] WRSEC_BYTES = 3'h2; // opcode plus one data byte
  localparam logic [2:0] PROG_MIN = 3'h5; // opcode, address, one datum
  localparam logic [7:0] STATUS_RST = 8'h00; // reserved bits read zero
  // link side view passed into the core clock
  typedef struct packed {
    logic cs_n; // frame select, idle high
    logic partial; // bits left over past the last whole byte
    logic tgl; // flips once per received byte
    logic [7:0] data; // last whole byte
  } sol_lnk_t;
  localparam sol_lnk_t LNK_IDLE = '{cs_n: 1'b1, default: '0};
  typedef enum logic [1:0] {S_OPC, S_ADDR, S_BODY} sol_st_t;

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == OP_PP) || (op == OP_QPP);
  endfunction : is_prog

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_RD) || (op == OP_FRD) || (op == OP_QRD);
  endfunction : is_read

  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == OP_SE) || (op == OP_BE32) || (op == OP_BE64) ||
      (op == OP_CE1) || (op == OP_CE2);
  endfunction : is_erase
endpackage : sol_pkg
`default_nettype wire

// [design/sol_sync.sv]
/*
  three-stage level synchroniser, vector wide; a bit takes its new value
  once the second and third stages agree.
  assumes: synchronous active-low reset on the receiving clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sol_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1; // metastable stage, read by s2 only
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_s2;
  logic [W-1:0] next_s3;
  logic [W-1:0] next_q;

  // shift, and accept per bit only where stages two and three agree
  always_comb
  begin
    next_s1 = d;
    next_s2 = s1;
    next_s3 = s2;
    next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      q <= next_q;
    end
  end
endmodule : sol_sync
`default_nettype wire

// [design/sol_link.sv]
/*
  serial-clock side: assembles bytes in single-line or quad mode and
  answers the lock-status read straight from the link clock.
  assumes: sclk runs only while cs_n is low; quad_command_mode steady
  across a frame; link_rst is an asynchronous reset from the core.
*/
`timescale 1ns/10ps
`default_nettype none
module sol_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic link_rst,
  input wire logic quad_command_mode,
  input wire logic [3:0] dq_in,
  input wire logic [1:0] lock_bits,
  output sol_pkg::sol_lnk_t ev,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_n
);
  logic [2:0] cnt; // bit position within the byte
  logic [7:0] shreg; // incoming shift register
  logic [7:0] byte_v; // last whole byte, held for the core
  logic tgl; // byte event toggle
  logic started; // first edge of this frame seen
  logic first_done; // opcode complete
  logic rd_sec; // frame is a lock-status read
  logic [1:0] sec_s1; // first stage, read by sec_s2 only
  logic [1:0] sec_s2;
  logic [1:0] sec_s3;
  logic [1:0] sec_q; // lock bits as seen on the link clock
  logic [2:0] next_cnt;
  logic [7:0] next_shreg;
  logic [7:0] next_byte;
  logic next_tgl;
  logic next_rd_sec;
  logic [1:0] next_sec_q;
  logic [3:0] next_dq;
  logic [3:0] next_oe_n;
  logic done;
  logic [7:0] ob;

  // byte assembly; a fresh frame restarts the count at its first edge
  always_comb
  begin
    next_cnt = (started ? cnt : 3'h0) +
      (quad_command_mode ? 3'h4 : 3'h1);
    next_shreg = quad_command_mode ? {shreg[3:0], dq_in} :
      {shreg[6:0], dq_in[0]};
    done = (next_cnt == 3'h0);
    next_byte = done ? next_shreg : byte_v;
    next_tgl = tgl ^ done;
    next_rd_sec = rd_sec ||
      (done && !first_done && next_shreg == sol_pkg::OP_RDSEC);
    next_sec_q = (~(sec_s2 ^ sec_s3) & sec_s3) |
      ((sec_s2 ^ sec_s3) & sec_q);
  end

  // link data registers; cnt survives the frame end so the core can see
  // whether the select rose on a byte boundary
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      cnt <= 3'h0;
      shreg <= 8'h00;
      byte_v <= 8'h00;
      tgl <= 1'b0;
      sec_s1 <= 2'h0;
      sec_s2 <= 2'h0;
      sec_s3 <= 2'h0;
      sec_q <= 2'h0;
    end
    else
    begin
      cnt <= next_cnt;
      shreg <= next_shreg;
      byte_v <= next_byte;
      tgl <= next_tgl;
      sec_s1 <= lock_bits;
      sec_s2 <= sec_s1;
      sec_s3 <= sec_s2;
      sec_q <= next_sec_q;
    end
  end

  // frame state, cleared by the frame's own select
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      started <= 1'b0;
      first_done <= 1'b0;
      rd_sec <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
      first_done <= first_done | done;
      rd_sec <= next_rd_sec;
    end
  end

  // status byte repeats for as long as the clock runs, busy or not
  always_comb
  begin
    ob = sol_pkg::STATUS_RST;
    ob[sol_pkg::SEC_FACT_BIT] = sec_q[0];
    ob[sol_pkg::SEC_CUST_BIT] = sec_q[1];
    next_dq = 4'h0;
    next_oe_n = 4'hf;
    if (rd_sec)
    begin
      if (quad_command_mode)
      begin
        next_dq = cnt[2] ? ob[3:0] : ob[7:4];
        next_oe_n = 4'h0;
      end
      else
      begin
        next_dq = {2'h0, ob[~cnt], 1'b0};
        next_oe_n = 4'hd;
      end
    end
  end

  // launch on the falling edge, release at once when select rises
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      dq_out <= 4'h0;
      dq_oe_n <= 4'hf;
    end
    else
    begin
      dq_out <= next_dq;
      dq_oe_n <= next_oe_n;
    end
  end

  // view handed to the core, synchronised there
  // one driver for the whole carrier, so no tool sees its fields split
  assign ev = '{cs_n: cs_n, partial: (cnt != 3'h0), tgl: tgl, data: byte_v};
endmodule : sol_link
`default_nettype wire

// [design/sol_otp_lock.sv]
/*
  secured one-time area lock control: mode entry and exit, lock status
  register, and the gating of writes while in the mode or once locked.
  assumes: sclk/cs_n/dq from the host; straps hold the non-volatile lock
  values across reset; the main program/erase engine obeys the gates.
*/
// Functional notes
// - opcode b1h enters one-time area mode
// - opcode c1h leaves one-time area mode
// - in mode, reads and programs hit area
// - in mode, refuse status and lock writes
// - locked area: reads only, program/erase ignored
// - opcode 2bh reads lock status anytime, repeatedly
// - status bit 0 shows factory lock
// - bit 1 customer lock, once set, permanent
// - lock write needs no write enable
// - lock write rejected unless byte-aligned end
// - in mode, main array writes blocked
// - serial 000-00f, customer area 010-1ff
// - commands accepted in single and quad mode
// - either lock freezes area and locks
`timescale 1ns/10ps
`default_nettype none
module sol_otp_lock (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_n,
  input wire logic quad_command_mode,
  input wire logic factory_lock_strap,
  input wire logic customer_lock_nv,
  output logic otp_mode,
  output logic main_wr_block,
  output logic sr_wr_block,
  output logic cmd_refused,
  output logic otp_prog_go,
  output logic [8:0] otp_addr,
  output logic factory_serial_field,
  output logic [7:0] otp_lock_status
);
  sol_pkg::sol_lnk_t lnk_raw; // link view, link clock
  sol_pkg::sol_lnk_t lnk; // link view after synchronising
  logic link_rst; // holds the link side in reset
  logic cs_q; // last accepted select level
  logic tgl_q; // last accepted byte toggle
  logic ev_d; // byte waiting to be taken
  logic exe_d1; // frame end, stage one
  logic exe_d2; // frame end, acted on
  sol_pkg::sol_st_t state; // position within the frame
  logic [7:0] opc; // opcode of this frame
  logic [23:0] addr; // address being gathered
  logic [2:0] nbyte; // whole bytes seen, saturating
  logic [7:0] wr_data; // data byte of a lock write
  logic fact_lock; // factory lock, caught at reset
  logic cust_lock; // customer lock
  logic locked;
  logic byte_ev;
  logic cs_rise;
  logic next_link_rst;
  logic next_ev_d;
  logic next_exe_d1;
  logic next_exe_d2;
  sol_pkg::sol_st_t next_state;
  logic [7:0] next_opc;
  logic [23:0] next_addr;
  logic [2:0] next_nbyte;
  logic [7:0] next_wr_data;
  logic next_cust_lock;
  logic next_otp_mode;
  logic next_cmd_refused;
  logic next_otp_prog_go;
  logic [8:0] next_otp_addr;
  logic next_serial;
  logic [7:0] next_status;

  // serial-clock front end
  sol_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .link_rst(link_rst),
    .quad_command_mode(quad_command_mode),
    .dq_in(dq_in),
    .lock_bits(otp_lock_status[1:0]),
    .ev(lnk_raw),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );

  // every link signal crosses by three stages; data is settled before
  // the toggle is acted on, one cycle after it is seen
  sol_sync #(
    .W($bits(sol_pkg::sol_lnk_t)),
    .INIT(sol_pkg::LNK_IDLE)
  ) u_sync (
    .clk(mclk),
    .rst_n(nrst),
    .d(lnk_raw),
    .q(lnk)
  );

  // either lock freezes the area and the lock state
  assign locked = fact_lock | cust_lock;
  assign byte_ev = (lnk.tgl != tgl_q) && !lnk.cs_n;
  assign cs_rise = lnk.cs_n && !cs_q;

  // event pipeline: byte taken a cycle late, frame end two cycles late
  // so the last byte is always counted before the frame is judged
  always_comb
  begin
    next_link_rst = 1'b0;
    next_ev_d = byte_ev;
    next_exe_d1 = cs_rise;
    next_exe_d2 = exe_d1;
  end

  // command decode and lock bookkeeping
  always_comb
  begin
    next_state = state;
    next_opc = opc;
    next_addr = addr;
    next_nbyte = nbyte;
    next_wr_data = wr_data;
    next_cust_lock = cust_lock;
    next_otp_mode = otp_mode;
    next_cmd_refused = 1'b0;
    next_otp_prog_go = 1'b0;
    next_otp_addr = otp_addr;
    next_serial = factory_serial_field;
    if (ev_d)
    begin
      // bytes beyond seven all count as many
      if (nbyte != 3'h7)
      begin
        next_nbyte = nbyte + 3'h1;
      end
      unique case (state)
        sol_pkg::S_OPC:
        begin
          next_opc = lnk.data;
          next_addr = 24'h000000;
          // in the mode, reads and programs carry an area address
          if (otp_mode && (sol_pkg::is_prog(lnk.data) ||
              sol_pkg::is_read(lnk.data)))
          begin
            next_state = sol_pkg::S_ADDR;
          end
          else
          begin
            next_state = sol_pkg::S_BODY;
          end
        end
        sol_pkg::S_ADDR:
        begin
          next_addr = {addr[15:0], lnk.data};
          if (next_nbyte == sol_pkg::ADDR_END)
          begin
            next_otp_addr = next_addr[8:0];
            next_serial = (next_addr <= sol_pkg::SERIAL_LAST);
            next_state = sol_pkg::S_BODY;
          end
        end
        sol_pkg::S_BODY:
        begin
          // first byte after the opcode is the lock write value
          if (nbyte == 3'h1)
          begin
            next_wr_data = lnk.data;
          end
        end
      endcase
    end
    if (exe_d2)
    begin
      next_state = sol_pkg::S_OPC;
      next_nbyte = 3'h0;
      if (nbyte == 3'h0)
      begin
        // select pulse with no whole byte: nothing to do
      end
      else if (opc == sol_pkg::OP_ENTER)
      begin
        next_otp_mode = 1'b1;
      end
      else if (opc == sol_pkg::OP_EXIT)
      begin
        next_otp_mode = 1'b0;
      end
      else if (opc == sol_pkg::OP_WRSEC)
      begin
        // no write enable is consulted here
        if (otp_mode || lnk.partial ||
            nbyte != sol_pkg::WRSEC_BYTES)
        begin
          next_cmd_refused = 1'b1;
        end
        else if (locked)
        begin
          next_cmd_refused = 1'b1;
        end
        else if (wr_data[sol_pkg::SEC_CUST_BIT])
        begin
          next_cust_lock = 1'b1;
        end
      end
      else if (otp_mode && (opc == sol_pkg::OP_WRSR1 ||
          opc == sol_pkg::OP_WRSR2))
      begin
        next_cmd_refused = 1'b1;
      end
      else if (otp_mode && sol_pkg::is_erase(opc))
      begin
        // the area is never erasable; main array is blocked in the mode
        next_cmd_refused = 1'b1;
      end
      else if (otp_mode && sol_pkg::is_prog(opc))
      begin
        // factory serial field is not customer programmable
        if (locked || addr > sol_pkg::OTP_LAST ||
            addr <= sol_pkg::SERIAL_LAST ||
            nbyte < sol_pkg::PROG_MIN)
        begin
          next_cmd_refused = 1'b1;
        end
        else
        begin
          next_otp_prog_go = 1'b1;
        end
      end
    end
    next_status = sol_pkg::STATUS_RST;
    next_status[sol_pkg::SEC_FACT_BIT] = fact_lock;
    next_status[sol_pkg::SEC_CUST_BIT] = next_cust_lock;
  end

  // registers; lock bits reload from their non-volatile straps in reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      link_rst <= 1'b1;
      cs_q <= 1'b1;
      tgl_q <= 1'b0;
      ev_d <= 1'b0;
      exe_d1 <= 1'b0;
      exe_d2 <= 1'b0;
      state <= sol_pkg::S_OPC;
      opc <= 8'h00;
      addr <= 24'h000000;
      nbyte <= 3'h0;
      wr_data <= 8'h00;
      fact_lock <= factory_lock_strap;
      cust_lock <= customer_lock_nv;
      otp_mode <= 1'b0;
      main_wr_block <= 1'b0;
      sr_wr_block <= 1'b0;
      cmd_refused <= 1'b0;
      otp_prog_go <= 1'b0;
      otp_addr <= 9'h000;
      factory_serial_field <= 1'b0;
      otp_lock_status <= sol_pkg::STATUS_RST;
    end
    else
    begin
      link_rst <= next_link_rst;
      cs_q <= lnk.cs_n;
      tgl_q <= lnk.tgl;
      ev_d <= next_ev_d;
      exe_d1 <= next_exe_d1;
      exe_d2 <= next_exe_d2;
      state <= next_state;
      opc <= next_opc;
      addr <= next_addr;
      nbyte <= next_nbyte;
      wr_data <= next_wr_data;
      cust_lock <= next_cust_lock;
      otp_mode <= next_otp_mode;
      main_wr_block <= next_otp_mode;
      sr_wr_block <= next_otp_mode;
      cmd_refused <= next_cmd_refused;
      otp_prog_go <= next_otp_prog_go;
      otp_addr <= next_otp_addr;
      factory_serial_field <= next_serial;
      otp_lock_status <= next_status;
    end
  end
endmodule : sol_otp_lock
`default_nettype wire

// [test/sol_otp_lock_assertions.sv]
/* port checker for the one-time area lock control.
   assumes: bound to every sol_otp_lock, core clock domain only. */
`timescale 1ns/10ps
`default_nettype none
module sol_otp_lock_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic [3:0] dq_oe_n,
  input wire logic otp_mode,
  input wire logic main_wr_block,
  input wire logic sr_wr_block,
  input wire logic cmd_refused,
  input wire logic otp_prog_go,
  input wire logic factory_serial_field,
  input wire logic [7:0] otp_lock_status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // both gates are the mode flag itself
  property p_gates; main_wr_block == otp_mode && sr_wr_block == otp_mode;
  endproperty
  a_gates: assert property (p_gates) else $error("gate mismatch");
  property p_rsvd; otp_lock_status[7:2] == 6'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  // customer lock never falls within a run
  property p_cust; $past(nrst) && $past(otp_lock_status[1]) |->
    otp_lock_status[1]; endproperty
  a_cust: assert property (p_cust) else $error("lock fell");
  // factory lock settles one cycle after release, then holds
  property p_fact; $past(nrst, 2) && $past(nrst) |->
    $stable(otp_lock_status[0]); endproperty
  a_fact: assert property (p_fact) else $error("factory moved");
  // commands only act once the frame has closed
  property p_mode; $changed(otp_mode) |-> cs_n; endproperty
  a_mode: assert property (p_mode) else $error("mode in frame");
  property p_stat; $changed(otp_lock_status) |-> cs_n; endproperty
  a_stat: assert property (p_stat) else $error("status in frame");
  property p_go; otp_prog_go |-> otp_mode && !factory_serial_field &&
    otp_lock_status[1:0] == 2'b00; endproperty
  a_go: assert property (p_go) else $error("bad program");
  property p_pulse; otp_prog_go || cmd_refused |=>
    !otp_prog_go && !cmd_refused; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_oe; cs_n && $past(cs_n) |-> dq_oe_n == 4'hf; endproperty
  a_oe: assert property (p_oe) else $error("drives idle");
endmodule : sol_otp_lock_checker
bind sol_otp_lock sol_otp_lock_checker u_chk (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .dq_oe_n(dq_oe_n),
  .otp_mode(otp_mode), .main_wr_block(main_wr_block),
  .sr_wr_block(sr_wr_block), .cmd_refused(cmd_refused),
  .otp_prog_go(otp_prog_go), .factory_serial_field(factory_serial_field),
  .otp_lock_status(otp_lock_status)
);
`default_nettype wire

// [test/sol_host.sv]
/* host controller model: frames commands on sclk/cs_n/dq.
   assumes: mode 0 clock, 12 ns period, still outside frames. */
`timescale 1ns/10ps
`default_nettype none
module sol_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] hdq,
  input wire logic quad,
  input wire logic [3:0] dq_w
);
  initial
  begin
    sclk = 1'b0;
    hdq = 4'h0;
    // a definite select rise after time zero clears the link frame state
    #1;
    cs_n = 1'b1;
  end
  // n whole bytes msb first, then stray bits; rd keeps last whole byte
  task automatic frame(input logic [47:0] b, input int n, input int extra,
    output logic [7:0] rd);
    int p;
    int epb;
    logic [7:0] sh;
    epb = quad ? 2 : 8;
    sh = 8'h00;
    cs_n = 1'b0;
    #6;
    for (int j = 0; j < n * epb + extra; j++)
    begin
      p = 8 * n - 1 - j * (quad ? 4 : 1);
      // unused lines toggle so a stale level is never trusted
      if (p < 0) hdq = ~hdq;
      else if (quad) hdq = b[p -: 4];
      else hdq = {~hdq[3:1], b[p]};
      #6;
      sh = quad ? {sh[3:0], dq_w} : {sh[6:0], dq_w[1]};
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
      if ((j + 1) % epb == 0) rd = sh;
    end
    #6;
    cs_n = 1'b1;
    hdq = ~hdq;
    #100; // frame gap well above 10 core cycles
  endtask : frame
endmodule : sol_host
`default_nettype wire

// [test/testbench.sv]
/* self-checking bench for the one-time area lock control.
   assumes: sol_host drives the link, straps change only in reset. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk, nrst, sclk, cs_n, quad, fs, cs, mode, mb, sb, rfs, go, fsf;
  logic [3:0] hdq, dq_w, dq_out, oe_n;
  logic [8:0] addr;
  logic [7:0] stat, rd;
  int miscompares, n_checks, n_ref, n_go;
  logic [47:0] rf[7] = '{48'h2f02, 48'h0100, 48'h3100, 48'h20000020,
    48'h0200000faa, 48'h02000200aa, 48'h02000020};
  int rn[7] = '{2, 2, 2, 4, 5, 5, 4};
  // wire level: device wins where it enables, host elsewhere
  assign dq_w = (hdq & oe_n) | (dq_out & ~oe_n);
  sol_otp_lock u_sol_otp_lock (.mclk(mclk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .dq_in(dq_w), .dq_out(dq_out), .dq_oe_n(oe_n),
    .quad_command_mode(quad), .factory_lock_strap(fs),
    .customer_lock_nv(cs), .otp_mode(mode), .main_wr_block(mb),
    .sr_wr_block(sb), .cmd_refused(rfs), .otp_prog_go(go),
    .otp_addr(addr), .factory_serial_field(fsf), .otp_lock_status(stat));
  sol_host u_sol_host (.sclk(sclk), .cs_n(cs_n), .hdq(hdq), .quad(quad),
    .dq_w(dq_w));
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  // pulse counters, one cycle pulses seen on every edge
  always @(posedge mclk)
  begin
    if (rfs === 1'b1) n_ref++;
    if (go === 1'b1) n_go++;
  end
  task automatic check(input string what, input logic [9:0] seen,
    input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // one frame, then the refusal and program pulses it caused
  task automatic cmd(input logic [47:0] b, input int n, input int extra,
    input logic er, input logic eg);
    int r0;
    int g0;
    logic [7:0] d;
    r0 = n_ref;
    g0 = n_go;
    u_sol_host.frame(b, n, extra, d);
    check("refused", 10'(n_ref - r0), {9'h000, er});
    check("prog_go", 10'(n_go - g0), {9'h000, eg});
  endtask : cmd
  task automatic do_reset(input logic f, input logic c);
    @(negedge mclk);
    nrst = 1'b0;
    fs = f;
    cs = c;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : do_reset
  initial
  begin
    #400000;
    miscompares++; // run hung
    wrap_up();
  end
  initial
  begin
    {nrst, quad, fs, cs} = 4'h0;
    {miscompares, n_checks, n_ref, n_go} = '0;
    do_reset(1'b0, 1'b0);
    check("status", {2'h0, stat}, 10'h000);
    u_sol_host.frame(48'h2b0000, 3, 0, rd);
    check("read", {2'h0, rd}, 10'h000);
    cmd(48'h2f02, 2, 3, 1'b1, 1'b0);
    check("status", {2'h0, stat}, 10'h000);
    cmd(48'hb1, 1, 0, 1'b0, 1'b0);
    check("gates", {7'h00, mode, mb, sb}, 10'h007);
    foreach (rf[i]) cmd(rf[i], rn[i], 0, 1'b1, 1'b0);
    cmd(48'h0200001055, 5, 0, 1'b0, 1'b1);
    check("addr", {fsf, addr}, 10'h010);
    cmd(48'h020001ff55, 5, 0, 1'b0, 1'b1);
    cmd(48'h0300000f, 4, 0, 1'b0, 1'b0);
    check("addr", {fsf, addr}, 10'h20f);
    u_sol_host.frame(48'h2b00, 2, 0, rd);
    check("read", {2'h0, rd}, 10'h000);
    quad = 1'b1;
    cmd(48'hc1, 1, 0, 1'b0, 1'b0);
    check("gates", {7'h00, mode, mb, sb}, 10'h000);
    cmd(48'h0200002055, 5, 0, 1'b0, 1'b0);
    cmd(48'h2f02, 2, 0, 1'b0, 1'b0);
    check("status", {2'h0, stat}, 10'h002);
    u_sol_host.frame(48'h2b0000, 3, 0, rd);
    check("read", {2'h0, rd}, 10'h002);
    quad = 1'b0;
    cmd(48'h2f00, 2, 0, 1'b1, 1'b0);
    check("status", {2'h0, stat}, 10'h002);
    cmd(48'hb1, 1, 0, 1'b0, 1'b0);
    cmd(48'h0200002055, 5, 0, 1'b1, 1'b0);
    cmd(48'h03000020, 4, 0, 1'b0, 1'b0);
    check("addr", {fsf, addr}, 10'h020);
    cmd(48'hc1, 1, 0, 1'b0, 1'b0);
    do_reset(1'b1, 1'b0);
    check("status", {2'h0, stat}, 10'h001);
    cmd(48'h2f02, 2, 0, 1'b1, 1'b0);
    check("status", {2'h0, stat}, 10'h001);
    cmd(48'hb1, 1, 0, 1'b0, 1'b0);
    cmd(48'h0200002055, 5, 0, 1'b1, 1'b0);
    do_reset(1'b0, 1'b1);
    check("status", {2'h0, stat}, 10'h002);
    check("gates", {7'h00, mode, mb, sb}, 10'h000);
    quad = 1'b1;
    cmd(48'hb1, 1, 0, 1'b0, 1'b0);
    check("gates", {7'h00, mode, mb, sb}, 10'h007);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
